// [pkg/ucc_pkg.sv]
`default_nettype none
package ucc_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int TI_UPD_MS = 200;
   localparam int EXT_MIN_HZ = 100_000;
   localparam logic [23:0] REF_HI = 24'd100000;
   localparam logic [23:0] REF_LO = 24'd10000;
   localparam logic [23:0] MUX_HI = 24'd20000;
   localparam logic [23:0] MUX_LO = 24'd2000;
   localparam logic [23:0] DIG_HI = MUX_HI / 24'd8;
   localparam logic [23:0] DIG_LO = MUX_LO / 24'd8;
   localparam logic [23:0] GAP_HI = 24'd2000000;
   localparam logic [23:0] GAP_LO = 24'd200000;
   localparam logic [23:0] TI_UPD = 24'(CLK_HZ / 1000 * TI_UPD_MS);
   localparam logic [7:0] EXT_TMO = 8'(CLK_HZ / EXT_MIN_HZ);
   localparam logic [3:0][9:0] WIN_M1 = {10'h3E7, 10'h063, 10'h009, 10'h000};
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_DISP = 8'h08;
   localparam logic [2:0] PH_EXT = 3'h0;
   localparam logic [2:0] PH_MHZ = 3'h1;
   localparam logic [2:0] PH_EDP = 3'h2;
   localparam logic [2:0] PH_OFF = 3'h3;
   localparam logic [2:0] PH_TEST = 3'h7;
   localparam logic [2:0] PH_LAST_RANGE = 3'h3;
   localparam logic [7:0] SEG_ALL = 8'hFF;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      FN_FREQ = 3'b000,
      FN_PERIOD = 3'b001,
      FN_RATIO = 3'b010,
      FN_TI = 3'b011,
      FN_UNIT = 3'b100,
      FN_OSC = 3'b101
   } ucc_fn_e;
   typedef enum logic [1:0] {
      ST_GAP = 2'b00,
      ST_ARM = 2'b01,
      ST_RUN = 2'b10,
      ST_UPD = 2'b11
   } ucc_st_e;
   typedef struct packed {
      logic [1:0] range;
      logic ext_osc;
      logic mhz1;
      logic ext_dp;
      logic off_sel;
      logic test;
      logic [2:0] dp_sel;
   } ucc_strap_s;
endpackage
`default_nettype wire

// [verilog/ucc_top.sv]
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Range sets window to 1, 10, 100 or 1000 reference counts.
// - Range change outside unit count aborts without display update.
// - Control input decodes several scan phases independently.
// - Phase four strap plus hold floats drivers, stops measuring.
// - Hold falling after display off starts a new measurement.
// - Display test shows all eights and points; off still blanks.
// - 1MHz select divides timebase by ten to the fourth.
// - 1MHz select moves point right in period and interval.
// - External timebase replaces the crystal when enabled.
// - External timebase below 100kHz falls back to crystal.
// - External point lights strapped digit, limits zero blanking.
// - Hold outside unit count aborts, clears main counter, keeps display latches.
// - Unit count hold freezes display while counting continues.
// - Reset input clears counter, aborts, shows all zeros.
// - Activity output low while measuring, high in gaps.
// - Point position follows function and range.
// - Overflow lights the point during digit eight time.
// - Primed single range measures one interval; repeats self-prime.
// - Interval waits 200ms after B falls before the next cycle.
// - Multiplex rate is timebase over 2e4, or 2e3 at 1MHz.
// - Measurement spacing is 2e6, or 2e5 at 1MHz, periods.
// - Range and control inputs decode by scan phase.
// - Only high-to-low input transitions are counted or timed.
// - Window end latches main counter, then clears it.
module ucc_top #(
   parameter logic [23:0] REF_HI = ucc_pkg::REF_HI,
   parameter logic [23:0] REF_LO = ucc_pkg::REF_LO,
   parameter logic [23:0] GAP_HI = ucc_pkg::GAP_HI,
   parameter logic [23:0] GAP_LO = ucc_pkg::GAP_LO,
   parameter logic [23:0] TI_UPD = ucc_pkg::TI_UPD
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic input_a,
   input wire logic input_b,
   input wire logic hold,
   input wire logic meas_reset,
   input wire logic range_in,
   input wire logic control_in,
   input wire logic point_select_in,
   input wire logic external_timebase_in,
   output logic [7:0] seg_out,
   output logic [7:0] digit_out,
   output logic drv_oe,
   output logic meas_gap,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   ucc_pkg::ucc_strap_s strap, next_strap;
   ucc_pkg::ucc_fn_e fn, next_fn;
   ucc_pkg::ucc_st_e st, next_st;
   logic [2:0] phase, next_phase;
   logic [23:0] dig_cnt, next_dig_cnt, div_cnt, next_div_cnt;
   logic [23:0] cnt, next_cnt, ref_max, dig_max, gap_max;
   logic [7:0] wd_cnt, next_wd_cnt;
   logic ext_fail, next_ext_fail, ext_q, a_q, b_q;
   logic tick, tb100, ph_end, off_now, ext_act, a_f, b_f;
   logic abort_q, next_abort_q, wd_trip, clr_q;
   logic [1:0] range_q;
   logic [31:0] main, next_main, disp, next_disp;
   logic ovf, next_ovf, dovf, next_dovf;
   logic [9:0] ref_cnt, next_ref_cnt;
   logic pa, next_pa, ti_open, next_ti_open;
   logic main_ev, ref_ev;
   logic [32:0] inc;
   logic [2:0] pos;
   logic [3:0] nib;
   logic blank;
   logic [7:0] next_seg;
   logic aw_got, next_aw_got, w_got, next_w_got;
   logic [7:0] waddr, next_waddr;
   logic [31:0] wdat, next_wdat, next_rdata;
   logic wstb0, next_wstb0, next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;

   function automatic logic [32:0] bcd_inc(input logic [31:0] v);
      logic [31:0] r;
      logic c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (c && r[i*4 +: 4] == 4'h9) begin
            r[i*4 +: 4] = 4'h0;
         end else if (c) begin
            r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
            c = 1'b0;
         end
      end
      return {c, r};
   endfunction

   function automatic logic [6:0] seg7(input logic [3:0] d);
      case (d)
         4'h0: return 7'h3F;
         4'h1: return 7'h06;
         4'h2: return 7'h5B;
         4'h3: return 7'h4F;
         4'h4: return 7'h66;
         4'h5: return 7'h6D;
         4'h6: return 7'h7D;
         4'h7: return 7'h07;
         4'h8: return 7'h7F;
         4'h9: return 7'h6F;
         default: return 7'h00;
      endcase
   endfunction

   // While the external timebase fails, every clock counts as a tick.
   assign ext_act = strap.ext_osc && !ext_fail;
   assign tick = ext_act ? (ext_q && !external_timebase_in) : 1'b1;
   assign off_now = strap.off_sel && hold;
   assign ref_max = strap.mhz1 ? REF_LO : REF_HI;
   assign dig_max = strap.mhz1 ? ucc_pkg::DIG_LO : ucc_pkg::DIG_HI;
   assign gap_max = strap.mhz1 ? GAP_LO : GAP_HI;
   // Switching to the shorter 1MHz counts can leave a counter past its new
   // end, so the divider end test is a bound; the digit end test is still a match.
   assign tb100 = tick && div_cnt >= ref_max - 24'h1;
   assign ph_end = tick && dig_cnt == dig_max - 24'h1;
   assign a_f = a_q && !input_a;
   assign b_f = b_q && !input_b;
   assign wd_trip = next_ext_fail && !ext_fail;

   always_comb begin
      next_div_cnt = div_cnt;
      next_dig_cnt = dig_cnt;
      next_phase = phase;
      next_strap = strap;
      next_wd_cnt = wd_cnt;
      next_ext_fail = ext_fail;
      if (tick) begin
         next_div_cnt = tb100 ? 24'h0 : div_cnt + 24'h1;
         next_dig_cnt = ph_end ? 24'h0 : dig_cnt + 24'h1;
      end
      if (ph_end) begin
         next_phase = phase + 3'h1;
      end
      if (ph_end && !off_now) begin
         if (range_in && phase <= ucc_pkg::PH_LAST_RANGE) begin
            next_strap.range = phase[1:0];
         end
         if (point_select_in) begin
            next_strap.dp_sel = phase;
         end
         case (phase)
            ucc_pkg::PH_EXT: next_strap.ext_osc = control_in;
            ucc_pkg::PH_MHZ: next_strap.mhz1 = control_in;
            ucc_pkg::PH_EDP: next_strap.ext_dp = control_in;
            ucc_pkg::PH_OFF: next_strap.off_sel = control_in;
            ucc_pkg::PH_TEST: next_strap.test = control_in;
            default: ;
         endcase
      end
      if (!strap.ext_osc) begin
         next_wd_cnt = 8'h0;
         next_ext_fail = 1'b0;
      end else if (ext_q && !external_timebase_in) begin
         next_wd_cnt = 8'h0;
      end else if (wd_cnt == ucc_pkg::EXT_TMO - 8'h1) begin
         next_ext_fail = 1'b1;
      end else begin
         next_wd_cnt = wd_cnt + 8'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 24'h0;
         dig_cnt <= 24'h0;
         phase <= 3'h0;
         strap <= '0;
         wd_cnt <= 8'h0;
         ext_fail <= 1'b0;
         ext_q <= 1'b0;
         a_q <= 1'b0;
         b_q <= 1'b0;
         range_q <= 2'h0;
         abort_q <= 1'b0;
         clr_q <= 1'b0;
      end else if (ce) begin
         div_cnt <= next_div_cnt;
         dig_cnt <= next_dig_cnt;
         phase <= next_phase;
         strap <= next_strap;
         wd_cnt <= next_wd_cnt;
         ext_fail <= next_ext_fail;
         ext_q <= external_timebase_in;
         a_q <= input_a;
         b_q <= input_b;
         range_q <= strap.range;
         abort_q <= next_abort_q;
         clr_q <= meas_reset;
      end
   end

   // Hold and display off stay asserted as long as the level lasts.
   always_comb begin
      next_abort_q = meas_reset || off_now || wd_trip;
      if (fn != ucc_pkg::FN_UNIT) begin
         next_abort_q = next_abort_q || hold;
         next_abort_q = next_abort_q || strap.range != range_q;
      end
   end

   always_comb begin
      main_ev = 1'b0;
      ref_ev = 1'b0;
      case (fn)
         ucc_pkg::FN_FREQ: begin
            main_ev = a_f;
            ref_ev = tb100;
         end
         ucc_pkg::FN_PERIOD: begin
            main_ev = tick;
            ref_ev = a_f;
         end
         ucc_pkg::FN_RATIO: begin
            main_ev = a_f;
            ref_ev = b_f;
         end
         ucc_pkg::FN_TI: begin
            main_ev = tick && ti_open;
            ref_ev = b_f && ti_open;
         end
         ucc_pkg::FN_UNIT: main_ev = a_f;
         ucc_pkg::FN_OSC: begin
            main_ev = tick;
            ref_ev = tb100;
         end
         default: ;
      endcase
   end

   always_comb begin
      next_st = st;
      next_main = main;
      next_ovf = ovf;
      next_disp = disp;
      next_dovf = dovf;
      next_ref_cnt = ref_cnt;
      next_cnt = cnt;
      next_pa = pa;
      next_ti_open = ti_open;
      inc = bcd_inc(main);
      case (st)
         ucc_pkg::ST_GAP: begin
            if (tick && cnt >= gap_max - 24'h1) begin
               next_st = ucc_pkg::ST_ARM;
               next_cnt = 24'h0;
            end else if (tick) begin
               next_cnt = cnt + 24'h1;
            end
         end
         ucc_pkg::ST_ARM: begin
            next_ref_cnt = 10'h0;
            if (fn == ucc_pkg::FN_UNIT) begin
               next_st = ucc_pkg::ST_RUN;
            end else if (fn == ucc_pkg::FN_TI) begin
               if (a_f) begin
                  next_pa = 1'b1;
               end
               if (b_f && pa) begin
                  next_pa = 1'b0;
                  next_st = ucc_pkg::ST_RUN;
               end
            end else if (ref_ev) begin
               next_st = ucc_pkg::ST_RUN;
            end
         end
         ucc_pkg::ST_RUN: begin
            if (main_ev) begin
               next_main = inc[31:0];
               next_ovf = ovf || inc[32];
            end
            if (fn == ucc_pkg::FN_TI && a_f) begin
               next_ti_open = 1'b1;
            end
            if (fn == ucc_pkg::FN_TI && b_f) begin
               next_ti_open = 1'b0;
            end
            if (fn == ucc_pkg::FN_UNIT) begin
               if (!hold) begin
                  next_disp = next_main;
                  next_dovf = next_ovf;
               end
            end else if (ref_ev &&
                         ref_cnt == ucc_pkg::WIN_M1[strap.range]) begin
               next_disp = next_main;
               next_dovf = next_ovf;
               next_main = 32'h0;
               next_ovf = 1'b0;
               next_cnt = 24'h0;
               if (fn == ucc_pkg::FN_TI) begin
                  next_st = ucc_pkg::ST_UPD;
               end else begin
                  next_st = ucc_pkg::ST_GAP;
               end
            end else if (ref_ev) begin
               next_ref_cnt = ref_cnt + 10'h1;
            end
         end
         ucc_pkg::ST_UPD: begin
            if (cnt == TI_UPD - 24'h1) begin
               next_st = ucc_pkg::ST_GAP;
               next_cnt = 24'h0;
            end else begin
               next_cnt = cnt + 24'h1;
            end
         end
         default: next_st = ucc_pkg::ST_GAP;
      endcase
      // The interval update time runs out even across an abort.
      if (abort_q) begin
         next_main = 32'h0;
         next_ovf = 1'b0;
         next_pa = 1'b0;
         next_ti_open = 1'b0;
         next_disp = clr_q ? 32'h0 : disp;
         next_dovf = clr_q ? 1'b0 : dovf;
         if (st != ucc_pkg::ST_UPD) begin
            next_st = ucc_pkg::ST_ARM;
            next_cnt = 24'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ucc_pkg::ST_ARM;
         main <= 32'h0;
         ovf <= 1'b0;
         disp <= 32'h0;
         dovf <= 1'b0;
         ref_cnt <= 10'h0;
         cnt <= 24'h0;
         pa <= 1'b0;
         ti_open <= 1'b0;
         meas_gap <= 1'b1;
      end else if (ce) begin
         st <= next_st;
         main <= next_main;
         ovf <= next_ovf;
         disp <= next_disp;
         dovf <= next_dovf;
         ref_cnt <= next_ref_cnt;
         cnt <= next_cnt;
         pa <= next_pa;
         ti_open <= next_ti_open;
         meas_gap <= next_st != ucc_pkg::ST_RUN;
      end
   end

   always_comb begin
      pos = {1'b0, strap.range} + 3'h1;
      if (fn == ucc_pkg::FN_RATIO) begin
         pos = {1'b0, strap.range};
      end else if (fn == ucc_pkg::FN_UNIT) begin
         pos = 3'h0;
      end else if (strap.mhz1 && (fn == ucc_pkg::FN_PERIOD ||
                                  fn == ucc_pkg::FN_TI)) begin
         pos = pos - 3'h1;
      end
      if (strap.ext_dp) begin
         pos = strap.dp_sel;
      end
      nib = disp[{phase, 2'b00} +: 4];
      blank = phase > pos && (disp >> {phase, 2'b00}) == 32'h0 && !dovf;
      next_seg = blank ? 8'h00 : {1'b0, seg7(nib)};
      if (phase == pos) begin
         next_seg[7] = 1'b1;
      end
      if (phase == 3'h7 && dovf) begin
         next_seg[7] = 1'b1;
      end
      if (strap.test) begin
         next_seg = ucc_pkg::SEG_ALL;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seg_out <= 8'h00;
         digit_out <= 8'h00;
         drv_oe <= 1'b0;
      end else if (ce) begin
         seg_out <= next_seg;
         digit_out <= 8'h01 << phase;
         drv_oe <= !off_now;
      end
   end

   assign s_axi_awready = ce && !aw_got && !s_axi_bvalid;
   assign s_axi_wready = ce && !w_got && !s_axi_bvalid;
   assign s_axi_arready = ce && !s_axi_rvalid;

   always_comb begin
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_waddr = waddr;
      next_wdat = wdat;
      next_wstb0 = wstb0;
      next_fn = fn;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_got = 1'b1;
         next_waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_got = 1'b1;
         next_wdat = s_axi_wdata;
         next_wstb0 = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_got && w_got) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = ucc_pkg::RESP_OK;
         if (waddr == ucc_pkg::A_CTRL) begin
            if (wstb0) begin
               next_fn = ucc_pkg::ucc_fn_e'(wdat[2:0]);
            end
         end else if (waddr != ucc_pkg::A_STAT &&
                      waddr != ucc_pkg::A_DISP) begin
            next_bresp = ucc_pkg::RESP_SLVERR;
         end
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = ucc_pkg::RESP_OK;
         if (s_axi_araddr == ucc_pkg::A_CTRL) begin
            next_rdata = {29'h0, fn};
         end else if (s_axi_araddr == ucc_pkg::A_STAT) begin
            next_rdata = {24'h0, ext_act, strap.range, ext_fail, dovf,
                          meas_gap, st};
         end else if (s_axi_araddr == ucc_pkg::A_DISP) begin
            next_rdata = disp;
         end else begin
            next_rdata = 32'h0;
            next_rresp = ucc_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         waddr <= 8'h00;
         wdat <= 32'h0;
         wstb0 <= 1'b0;
         fn <= ucc_pkg::FN_FREQ;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0;
      end else if (ce) begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         waddr <= next_waddr;
         wdat <= next_wdat;
         wstb0 <= next_wstb0;
         fn <= next_fn;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_off_float;
      ce && off_now |=> !drv_oe;
   endproperty
   a_off_float: assert property (p_off_float)
      else $error("Drivers not floated in display off.");
   property p_range_abort;
      ce && fn != ucc_pkg::FN_UNIT && strap.range != range_q |=> abort_q;
   endproperty
   a_range_abort: assert property (p_range_abort)
      else $error("Range change did not abort.");
   property p_abort;
      ce && abort_q && st != ucc_pkg::ST_UPD |=>
         st == ucc_pkg::ST_ARM && main == 32'h0;
   endproperty
   a_abort: assert property (p_abort)
      else $error("Abort did not clear the counter.");
   property p_keep;
      ce && abort_q && !clr_q |=> $stable(disp);
   endproperty
   a_keep: assert property (p_keep)
      else $error("Display changed during abort.");
   property p_unit;
      ce && fn == ucc_pkg::FN_UNIT && hold && !clr_q |=> $stable(disp);
   endproperty
   a_unit: assert property (p_unit)
      else $error("Unit count display not frozen.");
   property p_reset;
      ce && abort_q && clr_q |=> disp == 32'h0 && main == 32'h0;
   endproperty
   a_reset: assert property (p_reset)
      else $error("Reset did not show zeros.");
   property p_gap;
      meas_gap == (st != ucc_pkg::ST_RUN);
   endproperty
   a_gap: assert property (p_gap)
      else $error("Activity output wrong.");
   property p_ovf_dp;
      ce && dovf && phase == 3'h7 |=> seg_out[7];
   endproperty
   a_ovf_dp: assert property (p_ovf_dp)
      else $error("Overflow point missing.");
   property p_test;
      ce && strap.test |=> seg_out == ucc_pkg::SEG_ALL;
   endproperty
   a_test: assert property (p_test)
      else $error("Display test pattern wrong.");
   property p_ti_upd;
      $rose(st == ucc_pkg::ST_UPD) |-> (st == ucc_pkg::ST_UPD)[*8];
   endproperty
   a_ti_upd: assert property (p_ti_upd)
      else $error("Interval update cut short.");
   c_done: cover property ($rose(st == ucc_pkg::ST_GAP));
   c_off: cover property (ce && off_now ##1 !off_now);
   c_upd: cover property ($rose(st == ucc_pkg::ST_UPD));
endmodule // ucc_top
`default_nettype wire

// [testbench/ucc_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Strap network on the scan lines plus a pair of signal sources.
module ucc_far_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] digit_out,
   input wire logic [7:0] cm,
   input wire logic [7:0] rm,
   input wire logic src_en,
   output logic input_a,
   output logic input_b,
   output logic range_in,
   output logic control_in,
   output logic point_select_in,
   output logic external_timebase_in
);
   logic [3:0] div;
   assign control_in = |(digit_out & cm);
   assign range_in = |(digit_out & rm);
   // Digit eight carries the overflow point, so point select never uses it.
   assign point_select_in = digit_out[2];
   assign external_timebase_in = div[0];
   // B trails A by a cycle, so A always falls first.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= 4'h0;
         input_a <= 1'b1;
         input_b <= 1'b1;
      end else begin
         div <= div + {3'h0, src_en};
         input_a <= div[3];
         input_b <= input_a;
      end
   end
endmodule // ucc_far_model
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst_n, ce, hold, meas_reset, src_en, drv_oe, meas_gap;
   logic input_a, input_b, range_in, control_in, point_select_in;
   logic external_timebase_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] seg_out, digit_out, cm, rm, s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int fail_count = 0;
   int n_checks = 0;
   ucc_top #(.REF_HI(24'h32), .REF_LO(24'h0A), .GAP_HI(24'h64),
      .GAP_LO(24'h14), .TI_UPD(24'h28)) dut (.clk, .rst_n, .ce, .input_a,
      .input_b, .hold, .meas_reset, .range_in, .control_in, .point_select_in,
      .external_timebase_in, .seg_out, .digit_out, .drv_oe, .meas_gap,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   ucc_far_model far (.clk, .rst_n, .digit_out, .cm, .rm, .src_en, .input_a,
      .input_b, .range_in, .control_in, .point_select_in,
      .external_timebase_in);
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Ready levels are read at the falling edge, where they are settled.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(negedge clk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) break;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tv;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(negedge clk);
         ta = s_axi_arready;
         tv = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tv) break;
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic wait_gap(input logic lvl);
      int n;
      @(negedge clk);
      for (n = 0; n < 3000 && meas_gap !== lvl; n++)
         @(negedge clk);
      check(32'(meas_gap), 32'(lvl));
   endtask
   task automatic run_len(input int exp);
      int n;
      wait_gap(1'b1);
      wait_gap(1'b0);
      n = 0;
      while (meas_gap === 1'b0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      check(n, exp);
   endtask
   task automatic digit_len(input int exp);
      logic [7:0] d0;
      int n;
      repeat (2) begin
         d0 = digit_out;
         n = 0;
         while (digit_out === d0 && n < 5000) begin
            @(negedge clk);
            n++;
         end
      end
      check(n, exp);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial begin
      {rst_n, hold, meas_reset, src_en, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, cm, rm} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      ce = 1'b1;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(ucc_pkg::A_DISP);
      check(d, 32'h0);
      rd(ucc_pkg::A_STAT);
      check(32'(d[2:0]), 32'h5);
      rd(8'h0C);
      check(32'(r), 32'h2);
      wr(8'h10, 32'h0);
      check(32'(r), 32'h2);
      src_en <= 1'b1;
      run_len(50);
      rd(ucc_pkg::A_DISP);
      check(32'(d != 32'h0), 32'h1);
      e = d;
      hold <= 1'b1;
      repeat (300) @(posedge clk);
      rd(ucc_pkg::A_DISP);
      check(d, e);
      hold <= 1'b0;
      run_len(50);
      @(posedge clk);
      meas_reset <= 1'b1;
      repeat (3) @(posedge clk);
      meas_reset <= 1'b0;
      rd(ucc_pkg::A_DISP);
      check(d, 32'h0);
      rm <= 8'h02;
      cm <= 8'h02;
      repeat (22000) @(posedge clk);
      rd(ucc_pkg::A_STAT);
      check(32'(d[6:5]), 32'h1);
      digit_len(32'(ucc_pkg::DIG_LO));
      run_len(100);
      @(posedge clk);
      cm <= 8'h8A;
      hold <= 1'b1;
      repeat (2200) @(negedge clk);
      check(32'(drv_oe), 32'h0);
      @(posedge clk);
      hold <= 1'b0;
      wait_gap(1'b0);
      repeat (2200) @(negedge clk);
      check(32'(seg_out), 32'hFF);
      check(32'(drv_oe), 32'h1);
      wr(ucc_pkg::A_CTRL, 32'h4);
      check(32'(r), 32'h0);
      // Drop display off and test so hold only freezes the display.
      cm <= 8'h02;
      rd(ucc_pkg::A_CTRL);
      check(d, 32'h4);
      repeat (2200) @(posedge clk);
      hold <= 1'b1;
      rd(ucc_pkg::A_DISP);
      e = d;
      repeat (100) @(posedge clk);
      rd(ucc_pkg::A_DISP);
      check(d, e);
      hold <= 1'b0;
      repeat (100) @(posedge clk);
      rd(ucc_pkg::A_DISP);
      check(32'(d > e), 32'h1);
      conclude();
   end
endmodule // testbench
`default_nettype wire
